// ===== dv/srir_asserts.sv
/* Port assertions for srir_top.
   Assumes one mclk domain; bound into each srir_top. */
`timescale 1ns/1ns
module srir_asserts #(
   parameter int NUM_CHAN = 8
) (
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire logic [1:0]            bus_mode,
   input wire logic                  host_cs,
   input wire logic                  host_rd,
   input wire logic                  host_wr,
   input wire logic [7:0]            host_addr,
   input wire logic                  host_rdy,
   input wire logic [7:0]            host_rdata,
   input wire logic                  host_rvalid,
   input wire logic                  svc_active,
   input wire logic [2:0]            svc_chan,
   input wire logic [NUM_CHAN*8-1:0] rx_data_vec,
   input wire logic [NUM_CHAN*4-1:0] rx_cnt_vec,
   input wire logic                  rx_data_pop,
   input wire logic                  rx_stat_pop,
   input wire logic [2:0]            rx_pop_chan,
   input wire logic                  tx_valid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   function automatic logic hit(logic [7:0] o, logic [7:0] a, logic [1:0] m);
      return m == 2'h1 ? a == {o[6:0], 1'b0} :
             m == 2'h2 ? a == {o[6:0], 1'b1} : a == o;
   endfunction
   sequence rd_s;
      host_cs && host_rd && !host_wr;
   endsequence
   sequence svc_rd_s(logic [7:0] o);
      rd_s ##0 (svc_active && hit(o, host_addr, bus_mode));
   endsequence
   read_answer_a: assert property (rd_s |=> host_rvalid)
      else $error("read not answered");
   answer_cause_a: assert property (host_rvalid |-> $past(host_cs && host_rd && !host_wr))
      else $error("answer without read");
   count_read_a: assert property (svc_rd_s(8'h07) |=>
      host_rdata == {4'h0, $past(rx_cnt_vec[svc_chan*4 +: 4])}) else $error("count read wrong");
   data_read_a: assert property (svc_rd_s(8'h78) |-> (rx_data_pop && !rx_stat_pop &&
      rx_pop_chan == svc_chan) ##1 (host_rdata == $past(rx_data_vec[svc_chan*8 +: 8])))
      else $error("data read wrong");
   stat_pop_a: assert property (svc_rd_s(8'h7A) |-> rx_stat_pop && !rx_data_pop)
      else $error("status pop wrong");
   idle_read_a: assert property (rd_s ##0 !svc_active |-> (!rx_data_pop && !rx_stat_pop) ##1
      (host_rdata == 8'h00)) else $error("idle read not refused");
   pop_cause_a: assert property ((rx_data_pop || rx_stat_pop) |->
      host_cs && host_rd && !host_wr && svc_active) else $error("pop without read");
   rdy_cause_a: assert property (!host_wr |-> host_rdy)
      else $error("ready low without write");
   tx_fill_a: assert property (host_cs && host_wr && !host_rd && host_rdy && svc_active &&
      hit(8'h7B, host_addr, bus_mode)
      |=> tx_valid) else $error("tx write lost");
endmodule
bind srir_top srir_asserts #(.NUM_CHAN(NUM_CHAN)) u_srir_asserts (.*);

// ===== dv/srir_chan_model.sv
/* Channel-side model: rx FIFO heads and counts, tx drain.
   Assumes pops on mclk; stall comes from the bench. */
`timescale 1ns/1ns
module srir_chan_model (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        stall,
   input  wire logic        rx_data_pop,
   input  wire logic        rx_stat_pop,
   input  wire logic [2:0]  rx_pop_chan,
   output      logic        tx_ready,
   output      logic [63:0] rx_data_vec,
   output      logic [63:0] rx_stat_vec,
   output      logic [31:0] rx_cnt_vec
);
   logic [3:0] hd_r [8];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hd_r <= '{default: 4'h0};
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= !stall;
         if (rx_data_pop || rx_stat_pop) hd_r[rx_pop_chan] <= hd_r[rx_pop_chan] + 4'h1;
      end
   end
   // Count falls as bytes leave, so a stale count shows up
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         rx_data_vec[c*8 +: 8] = {c[2:0], 1'b0, hd_r[c]};
         rx_stat_vec[c*8 +: 8] = {hd_r[c], 1'b1, c[2:0]};
         rx_cnt_vec[c*4 +: 4] = 4'hF - hd_r[c];
      end
   end
endmodule

// ===== dv/tb_top.sv
/* Self-checking bench for srir_top with the channel model.
   Assumes a small tx FIFO depth so that it fills quickly. */
`timescale 1ns/1ns
module tb_top;
   logic        mclk = 0, rst = 1, host_cs = 0, host_rd = 0, host_wr = 0, svc_active = 0, stall = 1;
   logic        host_rdy, host_rvalid, rx_data_pop, rx_stat_pop, tx_valid, tx_ready;
   logic [1:0]  bus_mode = 2'h0;
   logic [2:0]  svc_chan = 3'h0, chan_access = 3'h0, rx_pop_chan, tx_chan;
   logic [7:0]  host_addr = 8'h00, host_wdata = 8'h00, host_rdata, tx_data, lf = 8'h5D;
   logic [63:0] rx_data_vec, rx_stat_vec;
   logic [31:0] rx_cnt_vec;
   logic [7:0]  rd_q[$];
   logic [10:0] tx_q[$];
   int          num_errors = 0, tests_run = 0;
   always #5 mclk = ~mclk;
   srir_top #(.TXF_DEPTH(2)) u_srir_top (.*);
   srir_chan_model u_srir_chan_model (.*);
   function automatic logic [7:0] nx(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [7:0] map(logic [7:0] o);
      return bus_mode == 2'h1 ? {o[6:0], 1'b0} : bus_mode == 2'h2 ? {o[6:0], 1'b1} : o;
   endfunction
   task automatic chk_tx(logic [10:0] got, logic [10:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(logic [7:0] got, logic [7:0] exp);
      chk_tx({3'h0, got}, {3'h0, exp});
   endtask
   task automatic idle;
      @(negedge mclk);
      host_rd = 0;
      host_wr = 0;
      host_cs = 0;
   endtask
   task automatic rd(logic [7:0] o);
      @(negedge mclk);
      host_cs = 1;
      host_rd = 1;
      host_addr = map(o);
      // Always differs from the interrupting channel, so a wrong select shows
      chan_access = svc_chan ^ (lf[2:0] | 3'h1);
      rd_q.push_back(!svc_active ? 8'h00 : o == 8'h07 ? {4'h0, rx_cnt_vec[svc_chan*4 +: 4]} :
         o == 8'h78 ? rx_data_vec[svc_chan*8 +: 8] : o == 8'h7A ? rx_stat_vec[svc_chan*8 +: 8] : 8'h00);
   endtask
   task automatic wr(logic [7:0] o, logic [7:0] d);
      @(negedge mclk);
      host_cs = 1;
      host_wr = 1;
      host_addr = map(o);
      host_wdata = d;
      if (svc_active && o == 8'h7B) tx_q.push_back({svc_chan, d});
      // Held until ready is seen, as a full FIFO may refuse
      repeat (40) begin
         #1;
         if (host_rdy === 1'b1) break;
         @(negedge mclk);
      end
      @(posedge mclk);
      idle;
   endtask
   task automatic give_verdict;
      $display("errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(negedge mclk) begin
      if (host_rvalid === 1'b1) chk_rd(host_rdata, rd_q.pop_front());
      if (tx_valid === 1'b1 && tx_ready === 1'b1) chk_tx({tx_chan, tx_data}, tx_q.pop_front());
   end
   initial begin
      repeat (2) @(posedge mclk);
      @(negedge mclk) rst = 0;
      chk_rd(host_rdata, 8'h00);
      rd(8'h07);
      idle;
      svc_active = 1;
      for (int m = 0; m < 4; m++) begin
         bus_mode = m[1:0];
         repeat (3) begin
            svc_chan = lf[2:0];
            lf = nx(lf);
            rd(8'h07);
            rd(8'h78);
            rd(8'h78);
            rd(8'h7A);
            rd(8'h07);
            rd(8'h55);
            idle;
            wr(8'h07, lf);
         end
         $display("mode %0d done", m);
      end
      svc_active = 0;
      rd(8'h78);
      idle;
      wr(8'h7B, 8'h11);
      $display("idle access done");
      svc_active = 1;
      bus_mode = 2'h0;
      fork
         for (int i = 0; i < 4; i++) begin
            wr(8'h7B, lf);
            lf = nx(lf);
         end
         begin
            repeat (12) @(negedge mclk);
            chk_rd({7'h00, host_rdy}, 8'h00);
            stall = 0;
         end
      join
      repeat (8) @(negedge mclk);
      chk_tx(11'(rd_q.size() + tx_q.size()), 11'h000);
      $display("tx fill done");
      give_verdict;
   end
   initial begin
      #20000;
      num_errors++;
      give_verdict;
   end
endmodule

// ===== rtl/srir_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ns
module srir_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    wr_ptr_nxt;
   logic [PW-1:0]    rd_ptr_r;
   logic [PW-1:0]    rd_ptr_nxt;
   logic [PW:0]      fill_r;
   logic [PW:0]      fill_nxt;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign in_ready  = (fill_r != (PW+1)'(DEPTH));
   assign out_valid = (fill_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rd_ptr_r];

   always_comb begin
      wr_ptr_nxt = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
      rd_ptr_nxt = pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
      fill_nxt   = fill_r;
      if (push && !pop) begin
         fill_nxt = fill_r + (PW+1)'(1);
      end else if (pop && !push) begin
         fill_nxt = fill_r - (PW+1)'(1);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         fill_r   <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         fill_r   <= fill_nxt;
      end
   end

   // Storage needs no reset; reads are gated by out_valid
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

endmodule

// ===== rtl/srir_pkg.sv
/*
 * Package for the service-request indirect register window:
 * host bus offsets, bus modes, field layout and sizes.
 * Assumes an eight-channel controller with one host bus on mclk.
 */
package srir_pkg;

   localparam int NUM_CHAN   = 8;
   localparam int CHAN_W     = 3;
   localparam int DATA_W     = 8;
   localparam int CNT_W      = 4;
   localparam int ADDR_W     = 8;
   localparam int TXF_DEPTH  = 16;

   // Register offsets in the plain 8-bit address map
   localparam logic [ADDR_W-1:0] OFS_RX_BYTE_COUNT = 8'h07;
   localparam logic [ADDR_W-1:0] OFS_RX_DATA       = 8'h78;
   localparam logic [ADDR_W-1:0] OFS_RX_STATUS     = 8'h7A;
   localparam logic [ADDR_W-1:0] OFS_TX_DATA       = 8'h7B;

   localparam logic [DATA_W-1:0] RX_BYTE_COUNT_RST = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO           = 8'h00;

   // Bus address layout: plain, shifted with low bit 0, shifted with low bit 1
   typedef enum logic [1:0] {
      SRIR_BUS_PLAIN  = 2'h0,
      SRIR_BUS_MUX_LO = 2'h1,
      SRIR_BUS_MUX_HI = 2'h2
   } srir_bus_mode_t;

   localparam int TXF_W = DATA_W + CHAN_W;

endpackage

// ===== rtl/srir_top.sv
/*
 * Service-request indirect register window of the host interface.
 * Assumes host strobes and channel FIFO signals are on mclk, and that
 * channel logic presents every channel's FIFO heads and counts in parallel.
 */
`timescale 1ns/1ns
module srir_top #(
   parameter int NUM_CHAN  = srir_pkg::NUM_CHAN,
   parameter int TXF_DEPTH = srir_pkg::TXF_DEPTH
) (
   input  wire logic                                     mclk,
   input  wire logic                                     rst,
   input  wire logic [1:0]                               bus_mode,
   input  wire logic                                     host_cs,
   input  wire logic                                     host_rd,
   input  wire logic                                     host_wr,
   input  wire logic [srir_pkg::ADDR_W-1:0]              host_addr,
   input  wire logic [srir_pkg::DATA_W-1:0]              host_wdata,
   output      logic                                     host_rdy,
   output      logic [srir_pkg::DATA_W-1:0]              host_rdata,
   output      logic                                     host_rvalid,
   input  wire logic                                     svc_active,
   input  wire logic [srir_pkg::CHAN_W-1:0]              svc_chan,
   input  wire logic [srir_pkg::CHAN_W-1:0]              chan_access,
   input  wire logic [NUM_CHAN*srir_pkg::DATA_W-1:0]     rx_data_vec,
   input  wire logic [NUM_CHAN*srir_pkg::DATA_W-1:0]     rx_stat_vec,
   input  wire logic [NUM_CHAN*srir_pkg::CNT_W-1:0]      rx_cnt_vec,
   output      logic                                     rx_data_pop,
   output      logic                                     rx_stat_pop,
   output      logic [srir_pkg::CHAN_W-1:0]              rx_pop_chan,
   output      logic                                     tx_valid,
   input  wire logic                                     tx_ready,
   output      logic [srir_pkg::DATA_W-1:0]              tx_data,
   output      logic [srir_pkg::CHAN_W-1:0]              tx_chan
);

   localparam int DW = srir_pkg::DATA_W;
   localparam int CW = srir_pkg::CHAN_W;
   localparam int NW = srir_pkg::CNT_W;

   // One-hot target of the current host address; NONE keeps the decode total
   typedef enum logic [4:0] {
      SRIR_SEL_NONE = 5'h01,
      SRIR_SEL_CNT  = 5'h02,
      SRIR_SEL_RXD  = 5'h04,
      SRIR_SEL_RXS  = 5'h08,
      SRIR_SEL_TXD  = 5'h10
   } srir_sel_t;

   logic [DW-1:0]           rdata_r;
   logic [DW-1:0]           rdata_nxt;
   logic                    rvalid_r;
   logic                    rvalid_nxt;
   logic [CW-1:0]           ctx_chan;
   srir_sel_t               sel;
   logic                    rd_take;
   logic                    wr_req;
   logic                    hit_rxd;
   logic                    hit_rxs;
   logic                    hit_txd;
   logic                    txf_in_valid;
   logic                    txf_in_ready;
   logic [srir_pkg::TXF_W-1:0] txf_out;
   logic [DW-1:0]           ctx_rx_data;
   logic [DW-1:0]           ctx_rx_stat;
   logic [NW-1:0]           ctx_rx_cnt;
   logic                    unused_chan_access;

   // Place a plain offset onto the bus address layout in use
   function automatic logic [srir_pkg::ADDR_W-1:0] bus_addr(
      input logic [1:0]                  mode,
      input logic [srir_pkg::ADDR_W-1:0] ofs
   );
      case (mode)
         srir_pkg::SRIR_BUS_MUX_LO: bus_addr = {ofs[srir_pkg::ADDR_W-2:0], 1'b0};
         srir_pkg::SRIR_BUS_MUX_HI: bus_addr = {ofs[srir_pkg::ADDR_W-2:0], 1'b1};
         default:                   bus_addr = ofs;
      endcase
   endfunction

   // One address, at most one target; first match wins
   function automatic srir_sel_t win_decode(
      input logic [1:0]                  mode,
      input logic [srir_pkg::ADDR_W-1:0] addr
   );
      if (addr == bus_addr(mode, srir_pkg::OFS_RX_BYTE_COUNT)) begin
         win_decode = SRIR_SEL_CNT;
      end else if (addr == bus_addr(mode, srir_pkg::OFS_RX_DATA)) begin
         win_decode = SRIR_SEL_RXD;
      end else if (addr == bus_addr(mode, srir_pkg::OFS_RX_STATUS)) begin
         win_decode = SRIR_SEL_RXS;
      end else if (addr == bus_addr(mode, srir_pkg::OFS_TX_DATA)) begin
         win_decode = SRIR_SEL_TXD;
      end else begin
         win_decode = SRIR_SEL_NONE;
      end
   endfunction

   // One channel's byte out of a flat per-channel vector
   function automatic logic [DW-1:0] chan_byte(
      input logic [NUM_CHAN*DW-1:0] vec,
      input logic [CW-1:0]          ch
   );
      chan_byte = vec[ch*DW +: DW];
   endfunction

   // Same for the four-bit count fields
   function automatic logic [NW-1:0] chan_nib(
      input logic [NUM_CHAN*NW-1:0] vec,
      input logic [CW-1:0]          ch
   );
      chan_nib = vec[ch*NW +: NW];
   endfunction

   // Context switch: only the interrupting channel is visible
   assign ctx_chan           = svc_chan;
   assign unused_chan_access = ^chan_access;

   // Pointer decode of the selected channel's FIFO heads, nothing stored
   assign ctx_rx_data = chan_byte(rx_data_vec, ctx_chan);
   assign ctx_rx_stat = chan_byte(rx_stat_vec, ctx_chan);
   assign ctx_rx_cnt  = chan_nib(rx_cnt_vec, ctx_chan);

   // Address match against the active layout
   assign sel     = win_decode(bus_mode, host_addr);
   assign hit_rxd = (sel == SRIR_SEL_RXD);
   assign hit_rxs = (sel == SRIR_SEL_RXS);
   assign hit_txd = (sel == SRIR_SEL_TXD);

   assign rd_take = host_cs && host_rd && !host_wr;
   assign wr_req  = host_cs && host_wr && !host_rd;

   // Writes to the count and receive windows fall through unused
   // Window is dead outside a service routine; host must keep away
   assign txf_in_valid = wr_req && hit_txd && svc_active;

   // Stall a host write to the transmit window while the transmit buffer is full
   assign host_rdy = !(txf_in_valid && !txf_in_ready);

   // Reads of unmapped offsets and of a dead window answer zero
   always_comb begin
      rdata_nxt  = srir_pkg::RD_ZERO;
      rvalid_nxt = rd_take;
      if (rd_take && svc_active) begin
         case (sel)
            SRIR_SEL_CNT: begin
               // Upper nibble forced to zero
               rdata_nxt = {{(DW-NW){1'b0}}, ctx_rx_cnt};
            end
            SRIR_SEL_RXD: begin
               rdata_nxt = ctx_rx_data;
            end
            SRIR_SEL_RXS: begin
               rdata_nxt = ctx_rx_stat;
            end
            SRIR_SEL_TXD: begin
               // Transmit window is write-only; a read gives zero
               rdata_nxt = srir_pkg::RD_ZERO;
            end
            default: begin
               rdata_nxt = srir_pkg::RD_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_r  <= srir_pkg::RX_BYTE_COUNT_RST;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign host_rdata  = rdata_r;
   assign host_rvalid = rvalid_r;

   // Pop on the edge that takes the read, so the next read already sees the
   // following head; a pop one cycle late would hand out one byte twice
   always_comb begin
      rx_data_pop = 1'b0;
      rx_stat_pop = 1'b0;
      if (rd_take && svc_active) begin
         rx_data_pop = hit_rxd;
         rx_stat_pop = hit_rxs;
      end
   end

   // Channel tag is the live context; meaningful only with a pop
   assign rx_pop_chan = ctx_chan;

   // Transmit bytes tagged with their channel so a late drain stays correct
   srir_fifo #(
      .WIDTH (srir_pkg::TXF_W),
      .DEPTH (TXF_DEPTH)
   ) u_txf (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (txf_in_valid),
      .in_ready  (txf_in_ready),
      .in_data   ({ctx_chan, host_wdata}),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (txf_out)
   );

   assign tx_data = txf_out[DW-1:0];
   assign tx_chan = txf_out[srir_pkg::TXF_W-1:DW];

endmodule
